// ### emc_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the MAC
 * control and station address registers.
 * Assumes inclusion by bare name from the MAC configuration sources.
 */
// Summary of operation
// - Control bit 23 set blocks reception while transmitting, except in loopback; clear receives own frames.
// - Loopback bit turns transmit data back to receive, nothing goes to PHY.
// - Duplex bit set lets transmit and receive run at the same time.
// - Full duplex skips the heartbeat check; its fail status is meaningless.
// - Promiscuous bit forwards every frame; resets to 0 as the bit table shows.
// - Pass-all-multicast bit forwards every multicast frame; the code leaves broadcast frames to bcast_ok_i instead.
// - Late collision bit allows retransmission after the normal collision window.
// - Single attempt bit: one try per frame, collided frame dropped.
// - Without single attempt, retry up to 16 times, then flag retry error.
// - Auto pad strip removes pad and FCS from frames under 46 bytes.
// - Back-off field picks 10, 8, 4 or 1 random bits; default 10.
// - Deferral check aborts a packet deferred more than 24,288 bit times.
// - Deferral counter runs while a packet waits on carrier sense.
// - A collision after transmission starts resets the deferral counter.
// - Deferral check clear means defer with no time limit.
// - Transmission happens only while the transmit enable bit is 1.
// - Reception happens only while the receive enable bit is 1.
// - Heartbeat disable bit suppresses the SQE heartbeat check.
`ifndef EMC_DEFINES_SVH
`define EMC_DEFINES_SVH

// ****************************************
// Register offsets (indirect)
// ****************************************
`define EMC_OFS_CTRL 16'h0000
`define EMC_OFS_ADDR_HI 16'h0004
`define EMC_OFS_ADDR_LO 16'h0008
`define EMC_OFS_STATUS 16'h000c

// ****************************************
// Control fields
// ****************************************
`define EMC_B_HBDIS 28
`define EMC_B_BLKSELF 23
`define EMC_B_LOOP 21
`define EMC_B_FDX 20
`define EMC_B_PROMISC 19
`define EMC_B_ALLMC 18
`define EMC_B_LATECOL 12
`define EMC_B_SINGLE 10
`define EMC_B_PADSTRIP 8
`define EMC_B_BOFF_HI 7
`define EMC_B_BOFF_LO 6
`define EMC_B_DEFCHK 5
`define EMC_B_TXON 3
`define EMC_B_RXON 2
`define EMC_CTRL_MASK 32'h10bc_15ec
`define EMC_CTRL_RST 32'h0000_0000
`define EMC_ADDR_HI_RST 32'hffff_ffff
`define EMC_ADDR_LO_RST 32'hffff_ffff

// ****************************************
// Timing and counts
// ****************************************
`define EMC_DEFER_BITS 24288
`define EMC_MAX_RETRY 16
`define EMC_MIN_FRAME 46
`define EMC_SLOT_BITS 512

`endif

// ### emc_mac_cfg.sv
/*
 * MAC control and station address registers, with the transmit attempt,
 * deferral and back-off policy and the receive gating they steer.
 * Assumes an indirect register port on the system clock and MII pins from
 * the PHY that are sampled through two flip-flops here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "emc_defines.svh"
module emc_mac_cfg
    import emc_pkg::*;
#(
    parameter int CLK_MHZ = 100,
    parameter int BIT_NS = 100,
    parameter int DEFER_CYC = `EMC_DEFER_BITS * BIT_NS * CLK_MHZ / 1000
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic phy_clk_i,
    input wire logic phy_crs_i,
    input wire logic phy_col_i,
    input wire logic phy_sqe_i,
    input wire logic tx_req_i,
    input wire logic tx_last_i,
    input wire logic [47:0] rx_dest_i,
    input wire logic [15:0] rx_len_i,
    input wire logic rx_frame_i,
    input wire logic rx_end_i,
    input wire logic bcast_ok_i,
    output logic phy_tx_en_o,
    output logic loop_tx_o,
    output logic tx_done_o,
    output logic tx_drop_o,
    output logic retry_err_o,
    output logic defer_abort_o,
    output logic rx_accept_o,
    output logic rx_strip_o,
    output logic hb_fail_o
);
    localparam int BIT_CYC = (BIT_NS * CLK_MHZ + 999) / 1000;

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] addr_hi_q, addr_hi_d;
    logic [31:0] addr_lo_q, addr_lo_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;

    function automatic logic [31:0] read_mux(input logic [15:0] a, input logic [31:0] c,
                                             input logic [31:0] h, input logic [31:0] l,
                                             input logic [31:0] s);
        case (a)
            `EMC_OFS_CTRL: read_mux = c;
            `EMC_OFS_ADDR_HI: read_mux = {16'h0000, h[15:0]};
            `EMC_OFS_ADDR_LO: read_mux = l;
            `EMC_OFS_STATUS: read_mux = s;
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    logic [31:0] status;
    logic tx_on, rx_on, fdx, single, late_ok, def_chk, loop, blk_self, hb_dis;
    logic [1:0] boff_sel;

    always_comb begin
        ctrl_d = ctrl_q;
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `EMC_OFS_CTRL: ctrl_d = reg_wdata_i & `EMC_CTRL_MASK;
                `EMC_OFS_ADDR_HI: addr_hi_d = {16'hffff, reg_wdata_i[15:0]};
                `EMC_OFS_ADDR_LO: addr_lo_d = reg_wdata_i;
                default: ;
            endcase
        end
        ack_d = reg_wr_i || reg_rd_i;
        rdata_d = reg_rd_i ? read_mux(reg_addr_i, ctrl_q, addr_hi_q, addr_lo_q, status)
                           : rdata_q;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `EMC_CTRL_RST;
            addr_hi_q <= `EMC_ADDR_HI_RST;
            addr_lo_q <= `EMC_ADDR_LO_RST;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            addr_hi_q <= addr_hi_d;
            addr_lo_q <= addr_lo_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    assign tx_on = ctrl_q[`EMC_B_TXON];
    assign rx_on = ctrl_q[`EMC_B_RXON];
    assign fdx = ctrl_q[`EMC_B_FDX];
    assign single = ctrl_q[`EMC_B_SINGLE];
    assign late_ok = ctrl_q[`EMC_B_LATECOL];
    assign def_chk = ctrl_q[`EMC_B_DEFCHK];
    assign loop = ctrl_q[`EMC_B_LOOP];
    assign blk_self = ctrl_q[`EMC_B_BLKSELF];
    assign hb_dis = ctrl_q[`EMC_B_HBDIS];
    assign boff_sel = ctrl_q[`EMC_B_BOFF_HI:`EMC_B_BOFF_LO];

    // ****************************************
    // PHY pin synchronisers
    // ****************************************
    logic [3:0] pins_s;
    logic clk_s_q, crs, col, sqe, bit_edge;

    emc_sync #(.WIDTH(4)) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i({phy_clk_i, phy_crs_i, phy_col_i, phy_sqe_i}),
        .sync_o(pins_s)
    );

    assign crs = pins_s[2];
    assign col = pins_s[1];
    assign sqe = pins_s[0];
    assign bit_edge = pins_s[3] && !clk_s_q;

    // ****************************************
    // Transmit attempt control
    // ****************************************
    emc_tx_state_type st_q, st_d;
    logic [31:0] defer_q, defer_d;
    logic [4:0] tries_q, tries_d;
    logic [9:0] boff_q, boff_d;
    logic [15:0] lfsr_q, lfsr_d;
    logic [15:0] slot_q, slot_d;
    logic txen_q, txen_d, loop_q, loop_d, done_q, done_d, drop_q, drop_d;
    logic rerr_q, rerr_d, dabort_q, dabort_d, hb_q, hb_d, acc_q, acc_d, strip_q, strip_d;
    logic busy, late, filt_acc, filt_strip;
    logic [9:0] boff_mask;

    // Medium counts busy only in half duplex; full duplex ignores carrier
    assign busy = crs && !fdx;
    assign late = slot_q >= 16'(`EMC_SLOT_BITS);

    always_comb begin
        case (boff_sel)
            2'b00: boff_mask = 10'h3ff;
            2'b01: boff_mask = 10'h0ff;
            2'b10: boff_mask = 10'h00f;
            default: boff_mask = 10'h001;
        endcase
    end

    always_comb begin
        st_d = st_q;
        defer_d = defer_q;
        tries_d = tries_q;
        boff_d = boff_q;
        slot_d = slot_q;
        lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        done_d = 1'b0;
        drop_d = 1'b0;
        rerr_d = 1'b0;
        dabort_d = 1'b0;
        case (st_q)
            TX_IDLE: begin
                defer_d = 32'd0;
                tries_d = 5'd0;
                if (tx_req_i && tx_on) begin
                    st_d = TX_DEFER;
                end
            end
            TX_DEFER: begin
                if (!tx_on) begin
                    st_d = TX_IDLE;
                end else if (busy) begin
                    defer_d = defer_q + 32'd1;
                    if (def_chk && defer_q >= 32'(DEFER_CYC)) begin
                        dabort_d = 1'b1;
                        st_d = TX_DONE;
                    end
                end else begin
                    slot_d = 16'd0;
                    st_d = TX_SEND;
                end
            end
            TX_SEND: begin
                if (bit_edge) begin
                    slot_d = slot_q + 16'd1;
                end
                if (col && !fdx) begin
                    defer_d = 32'd0;
                    if (single || (late && !late_ok)) begin
                        drop_d = 1'b1;
                        st_d = TX_DONE;
                    end else if (tries_q >= 5'(`EMC_MAX_RETRY)) begin
                        rerr_d = 1'b1;
                        st_d = TX_DONE;
                    end else begin
                        tries_d = tries_q + 5'd1;
                        boff_d = lfsr_q[9:0] & boff_mask;
                        slot_d = 16'd0;
                        st_d = TX_BACKOFF;
                    end
                end else if (!tx_on) begin
                    // Transmit switched off mid-frame: give the frame up at once
                    drop_d = 1'b1;
                    st_d = TX_DONE;
                end else if (tx_last_i) begin
                    done_d = 1'b1;
                    st_d = TX_DONE;
                end
            end
            TX_BACKOFF: begin
                // Timed on the system clock: the PHY bit clock may stand still
                // while the medium is idle, which would stall a count of its edges
                if (boff_q == 10'd0) begin
                    st_d = TX_DEFER;
                end else if (slot_q >= 16'(BIT_CYC - 1)) begin
                    slot_d = 16'd0;
                    boff_d = boff_q - 10'd1;
                end else begin
                    slot_d = slot_q + 16'd1;
                end
            end
            TX_DONE: st_d = TX_IDLE;
            default: st_d = TX_IDLE;
        endcase
        txen_d = (st_d == TX_SEND) && !loop;
        loop_d = (st_d == TX_SEND) && loop;
        hb_d = hb_q;
        if (st_q == TX_DONE) begin
            hb_d = 1'b0;
        end else if (st_q == TX_SEND && sqe && !fdx && !hb_dis) begin
            hb_d = 1'b1;
        end
        acc_d = 1'b0;
        strip_d = 1'b0;
        if (rx_end_i && rx_frame_i && rx_on
            && !(blk_self && (txen_q || loop_q) && !loop)) begin
            acc_d = filt_acc;
            strip_d = filt_acc && filt_strip;
        end
    end

    emc_rx_filter u_filter (
        .dest_i(rx_dest_i),
        .station_i({addr_hi_q[15:0], addr_lo_q}),
        .length_i(rx_len_i),
        .promisc_i(ctrl_q[`EMC_B_PROMISC]),
        .allmc_i(ctrl_q[`EMC_B_ALLMC]),
        .bcast_ok_i(bcast_ok_i),
        .pad_strip_i(ctrl_q[`EMC_B_PADSTRIP]),
        .accept_o(filt_acc),
        .strip_o(filt_strip)
    );

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= TX_IDLE;
            defer_q <= 32'd0;
            tries_q <= 5'd0;
            boff_q <= 10'd0;
            slot_q <= 16'd0;
            lfsr_q <= 16'hace1;
            clk_s_q <= 1'b0;
            txen_q <= 1'b0;
            loop_q <= 1'b0;
            done_q <= 1'b0;
            drop_q <= 1'b0;
            rerr_q <= 1'b0;
            dabort_q <= 1'b0;
            hb_q <= 1'b0;
            acc_q <= 1'b0;
            strip_q <= 1'b0;
        end else begin
            st_q <= st_d;
            defer_q <= defer_d;
            tries_q <= tries_d;
            boff_q <= boff_d;
            slot_q <= slot_d;
            lfsr_q <= lfsr_d;
            clk_s_q <= pins_s[3];
            txen_q <= txen_d;
            loop_q <= loop_d;
            done_q <= done_d;
            drop_q <= drop_d;
            rerr_q <= rerr_d;
            dabort_q <= dabort_d;
            hb_q <= hb_d;
            acc_q <= acc_d;
            strip_q <= strip_d;
        end
    end

    assign status = {27'h0000000, hb_q, txen_q, loop_q, st_q == TX_DEFER, st_q == TX_BACKOFF};
    assign reg_rdata_o = rdata_q;
    assign reg_ack_o = ack_q;
    assign phy_tx_en_o = txen_q;
    assign loop_tx_o = loop_q;
    assign tx_done_o = done_q;
    assign tx_drop_o = drop_q;
    assign retry_err_o = rerr_q;
    assign defer_abort_o = dabort_q;
    assign rx_accept_o = acc_q;
    assign rx_strip_o = strip_q;
    assign hb_fail_o = hb_q;

    // ****************************************
    // Checks
    // ****************************************
    a_tx_gate_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !tx_on |=> !phy_tx_en_o) else $error("tx enable without tx_on");
    a_loop_no_phy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        loop_tx_o |-> !phy_tx_en_o) else $error("loopback drove phy");
    a_rx_gate_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!rx_on && rx_end_i) |=> !rx_accept_o) else $error("rx accepted while off");
    a_fdx_no_hb: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (fdx && !hb_fail_o) |=> !hb_fail_o) else $error("heartbeat in full duplex");
    a_hbdis_no_hb: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (hb_dis && !hb_fail_o) |=> !hb_fail_o) else $error("heartbeat while disabled");
    a_single_no_retry: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        single |-> !retry_err_o) else $error("retry error in single mode");
    a_defer_unlimited: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !$past(def_chk) |-> !defer_abort_o) else $error("abort without check");
    a_col_clears_defer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (st_q == TX_SEND && col && !fdx) |=> defer_q == 32'd0) else $error("defer kept");
    a_defer_limit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        defer_abort_o |-> $past(defer_q) >= 32'(DEFER_CYC)) else $error("early abort");
    c_tx_done: cover property (@(posedge clock_i) tx_done_o);
    c_retry_err: cover property (@(posedge clock_i) retry_err_o);
    c_rx_strip: cover property (@(posedge clock_i) rx_strip_o);
endmodule
`default_nettype wire

// ### emc_mac_cfg_tb_top.sv
/*
 * Self-checking bench for the MAC configuration block.
 * Assumes emc_pkg, the design sources and the PHY model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module emc_mac_cfg_tb_top;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic tx_req_i = 1'b0;
    logic tx_last_i = 1'b0;
    logic [47:0] rx_dest_i = 48'h0;
    logic [15:0] rx_len_i = 16'h0000;
    logic rx_frame_i = 1'b0;
    logic rx_end_i = 1'b0;
    logic bcast_ok_i = 1'b1;
    logic busy = 1'b0;
    logic col_cmd = 1'b0;
    logic sqe_cmd = 1'b0;
    logic [31:0] reg_rdata_o;
    logic reg_ack_o, phy_clk, phy_crs, phy_col, phy_sqe, phy_tx_en_o, loop_tx_o;
    logic tx_done_o, tx_drop_o, retry_err_o, defer_abort_o, rx_accept_o, rx_strip_o, hb_fail_o;
    int err_total = 0;
    int checks = 0;
    logic [47:0] stn = 48'h1234_5678_9abc;

    always #5 clock_i = ~clock_i;

    // Short deferral limit keeps the abort case within a few hundred cycles
    emc_mac_cfg #(.DEFER_CYC(50)) i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .phy_clk_i(phy_clk),
        .phy_crs_i(phy_crs), .phy_col_i(phy_col), .phy_sqe_i(phy_sqe),
        .tx_req_i(tx_req_i), .tx_last_i(tx_last_i), .rx_dest_i(rx_dest_i),
        .rx_len_i(rx_len_i), .rx_frame_i(rx_frame_i), .rx_end_i(rx_end_i),
        .bcast_ok_i(bcast_ok_i), .phy_tx_en_o(phy_tx_en_o), .loop_tx_o(loop_tx_o),
        .tx_done_o(tx_done_o), .tx_drop_o(tx_drop_o), .retry_err_o(retry_err_o),
        .defer_abort_o(defer_abort_o), .rx_accept_o(rx_accept_o),
        .rx_strip_o(rx_strip_o), .hb_fail_o(hb_fail_o)
    );

    emc_phy_model i_phy (
        .busy_i(busy), .col_cmd_i(col_cmd), .sqe_cmd_i(sqe_cmd), .tx_en_i(phy_tx_en_o),
        .phy_clk_o(phy_clk), .crs_o(phy_crs), .col_o(phy_col), .sqe_o(phy_sqe)
    );

    // ****************************************
    // Checking and access tasks
    // ****************************************
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One-cycle strobe; ack and read data stand in the following cycle
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        @(negedge clock_i);
        reg_addr_i = a;
        reg_wr_i = w;
        reg_rd_i = !w;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        chk({47'h0, reg_ack_o}, 48'h1);
        if (!w) begin
            chk({16'h0, reg_rdata_o}, {16'h0, e});
        end
    endtask

    // Collects one-cycle pulses: {retry, done, drop, abort, strip, accept}
    task automatic watch(input int n, output logic [5:0] s);
        s = 6'h00;
        repeat (n) begin
            @(negedge clock_i);
            s |= {retry_err_o, tx_done_o, tx_drop_o, defer_abort_o, rx_strip_o, rx_accept_o};
            tx_last_i = 1'b0;
            rx_end_i = 1'b0;
            rx_frame_i = 1'b0;
        end
    endtask

    task automatic rx(input logic [47:0] d, input logic [15:0] len, input logic [1:0] e);
        logic [5:0] s;
        @(negedge clock_i);
        rx_dest_i = d;
        rx_len_i = len;
        rx_frame_i = 1'b1;
        @(negedge clock_i);
        rx_end_i = 1'b1;
        watch(5, s);
        chk({46'h0, s[1:0]}, {46'h0, e});
    endtask

    task automatic tx_start(input logic ep, input logic el);
        @(negedge clock_i);
        tx_req_i = 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(negedge clock_i);
            if (phy_tx_en_o === 1'b1 || loop_tx_o === 1'b1) break;
        end
        chk({46'h0, phy_tx_en_o, loop_tx_o}, {46'h0, ep, el});
    endtask

    task automatic tx_end();
        logic [5:0] s;
        @(negedge clock_i);
        tx_last_i = 1'b1;
        tx_req_i = 1'b0;
        watch(6, s);
        chk({47'h0, s[4]}, 48'h1);
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [5:0] s;
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        acc(0, 16'h0000, 32'h0, 32'h0000_0000);
        acc(0, 16'h0004, 32'h0, 32'h0000_ffff);
        acc(0, 16'h0008, 32'h0, 32'hffff_ffff);
        acc(0, 16'h0010, 32'h0, 32'h0000_0000);
        acc(1, 16'h0000, 32'hffff_ffff, 32'h0);
        acc(0, 16'h0000, 32'h0, 32'h10bc_15ec);
        for (int b = 0; b < 4; b++) begin
            acc(1, 16'h0000, 32'(b) << 6, 32'h0);
            acc(0, 16'h0000, 32'h0, 32'(b) << 6);
        end
        acc(1, 16'h0004, 32'habcd_1234, 32'h0);
        acc(1, 16'h0008, 32'h5678_9abc, 32'h0);
        acc(0, 16'h0004, 32'h0, 32'h0000_1234);
        acc(0, 16'h0008, 32'h0, 32'h5678_9abc);
        acc(1, 16'h0000, 32'h0000_0004, 32'h0);
        rx(stn, 16'd64, 2'b01);
        rx(48'h0200_0000_0001, 16'd64, 2'b00);
        rx(48'h0100_0000_0001, 16'd64, 2'b00);
        rx(48'hffff_ffff_ffff, 16'd64, 2'b01);
        bcast_ok_i = 1'b0;
        rx(48'hffff_ffff_ffff, 16'd64, 2'b00);
        acc(1, 16'h0000, 32'h0004_0004, 32'h0);
        rx(48'h0100_0000_0001, 16'd64, 2'b01);
        acc(1, 16'h0000, 32'h0008_0004, 32'h0);
        rx(48'h0200_0000_0001, 16'd64, 2'b01);
        acc(1, 16'h0000, 32'h0000_0104, 32'h0);
        rx(stn, 16'd40, 2'b11);
        rx(stn, 16'd46, 2'b01);
        acc(1, 16'h0000, 32'h0000_0000, 32'h0);
        rx(stn, 16'd64, 2'b00);
        tx_start(1'b0, 1'b0);
        tx_req_i = 1'b0;
        acc(1, 16'h0000, 32'h0000_000c, 32'h0);
        tx_start(1'b1, 1'b0);
        rx(stn, 16'd64, 2'b01);
        tx_end();
        acc(1, 16'h0000, 32'h0080_000c, 32'h0);
        sqe_cmd = 1'b1;
        tx_start(1'b1, 1'b0);
        rx(stn, 16'd64, 2'b00);
        chk({47'h0, hb_fail_o}, 48'h1);
        tx_end();
        acc(1, 16'h0000, 32'h0010_000c, 32'h0);
        tx_start(1'b1, 1'b0);
        rx(stn, 16'd64, 2'b01);
        chk({47'h0, hb_fail_o}, 48'h0);
        tx_end();
        acc(1, 16'h0000, 32'h1000_000c, 32'h0);
        tx_start(1'b1, 1'b0);
        watch(8, s);
        chk({47'h0, hb_fail_o}, 48'h0);
        tx_end();
        sqe_cmd = 1'b0;
        acc(1, 16'h0000, 32'h0020_000c, 32'h0);
        tx_start(1'b0, 1'b1);
        tx_end();
        acc(1, 16'h0000, 32'h0000_0408, 32'h0);
        tx_start(1'b1, 1'b0);
        // No further packet waits, so the dropped frame is not followed by a new one
        tx_req_i = 1'b0;
        col_cmd = 1'b1;
        watch(20, s);
        col_cmd = 1'b0;
        chk({47'h0, s[3]}, 48'h1);
        chk({47'h0, s[5]}, 48'h0);
        chk({47'h0, phy_tx_en_o}, 48'h0);
        acc(1, 16'h0000, 32'h0000_0008, 32'h0);
        busy = 1'b1;
        @(negedge clock_i);
        tx_req_i = 1'b1;
        watch(150, s);
        chk({47'h0, s[2]}, 48'h0);
        chk({47'h0, phy_tx_en_o}, 48'h0);
        busy = 1'b0;
        tx_start(1'b1, 1'b0);
        tx_end();
        // One back-off bit keeps seventeen collisions within a few hundred cycles
        acc(1, 16'h0000, 32'h0000_00c8, 32'h0);
        tx_start(1'b1, 1'b0);
        tx_req_i = 1'b0;
        col_cmd = 1'b1;
        watch(400, s);
        col_cmd = 1'b0;
        chk({47'h0, s[5]}, 48'h1);
        chk({47'h0, s[3]}, 48'h0);
        chk({47'h0, phy_tx_en_o}, 48'h0);
        // Abort case last: the state left behind after an abort is not pinned down
        acc(1, 16'h0000, 32'h0000_0028, 32'h0);
        busy = 1'b1;
        @(negedge clock_i);
        tx_req_i = 1'b1;
        watch(80, s);
        tx_req_i = 1'b0;
        busy = 1'b0;
        chk({47'h0, s[2]}, 48'h1);
        finish_test();
    end

    // Whole sequence takes under 3000 cycles
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire

// ### emc_phy_model.sv
/*
 * Behavioural 10/100 PHY as seen from the MAC pins.
 * Assumes the bench commands medium activity through the _i controls.
 */
`timescale 1ns/1ps
`default_nettype none
module emc_phy_model (
    input wire logic busy_i,
    input wire logic col_cmd_i,
    input wire logic sqe_cmd_i,
    input wire logic tx_en_i,
    output logic phy_clk_o,
    output logic crs_o,
    output logic col_o,
    output logic sqe_o
);
    // ****************************************
    // Medium
    // ****************************************
    // Half duplex carrier also follows our own transmit, as on a real segment
    assign crs_o = busy_i | tx_en_i;
    assign col_o = col_cmd_i & tx_en_i;
    assign sqe_o = sqe_cmd_i & tx_en_i;
    // Bit clock stands low between frames, so nothing may lean on it when idle
    initial phy_clk_o = 1'b0;
    always begin
        #62.5;
        phy_clk_o = (busy_i | tx_en_i) ? ~phy_clk_o : 1'b0;
    end
endmodule
`default_nettype wire

// ### emc_pkg.sv
/*
 * Types shared by the MAC configuration modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package emc_pkg;
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_DEFER,
        TX_SEND,
        TX_BACKOFF,
        TX_DONE
    } emc_tx_state_type;
endpackage

// ### emc_rx_filter.sv
/*
 * Receive address filter and pad strip decision for one frame.
 * Assumes the destination address and length are stable with rx_end_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "emc_defines.svh"
module emc_rx_filter (
    input wire logic [47:0] dest_i,
    input wire logic [47:0] station_i,
    input wire logic [15:0] length_i,
    input wire logic promisc_i,
    input wire logic allmc_i,
    input wire logic bcast_ok_i,
    input wire logic pad_strip_i,
    output logic accept_o,
    output logic strip_o
);
    logic is_bcast;
    logic is_mcast;

    always_comb begin
        is_bcast = (dest_i == 48'hffff_ffff_ffff);
        is_mcast = dest_i[40] && !is_bcast;
        accept_o = promisc_i
            || (allmc_i && is_mcast)
            || (dest_i == station_i) || (is_bcast && bcast_ok_i);
        strip_o = pad_strip_i && (length_i < 16'(`EMC_MIN_FRAME));
    end
endmodule
`default_nettype wire

// ### emc_sync.sv
/*
 * Two flip-flop synchroniser for pins from the PHY side.
 * Assumes clock_i is the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module emc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire
